// File: verification/lcr_link_src.sv
// forwarded bit clock source, 800 ns period
// assumes run is driven from the bench clock domain
`timescale 1ns/1ps
module lcr_link_src (
	run, // frame active
	bitClk // link clock, low outside frames once the 800 ns period under way (low then high phase) ends
);
	input wire logic run;
	output logic bitClk;
	always begin
		bitClk = 1'b0;
		wait (run);
		#400 bitClk = 1'b1;
		#400;
	end
endmodule

// File: verification/tb_top.sv
// bench for the lane 13-16 control register bank
// assumes lcr_pkg and lcr_regs are compiled first
`timescale 1ns/1ps
module tb_top;
	import lcr_pkg::*;
	logic clk, reset, wrStrobe, rdStrobe, perLanePatternEnable, run, bitClk, rise;
	lcr_addr_t addr;
	lcr_word_t wrData, rdData;
	lcr_pattern_t pat15, pat16;
	lcr_lane_t dig, drv, ana, flip;
	lcr_delay_t dly;
	logic signed [15:0] shiftPs;
	int n_errors = 0, n_tests = 0, nRise = 0;
	int dl[5] = '{0, 1, 2, -2, -1};
	lcr_link_src lcr_link_src_inst (.run(run), .bitClk(bitClk));
	lcr_regs lcr_regs_inst (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .perLanePatternEnable(perLanePatternEnable),
		.forwardedBitClock(bitClk), .laneFifteenPatternCode(pat15), .laneSixteenPatternCode(pat16),
		.digitalOff(dig), .driverOff(drv), .analogOff(ana), .flipData(flip), .forwardedClockDelay(dly),
		.forwardedClockShiftPs(shiftPs), .forwardedClockRise(rise));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) if (rise === 1'b1) nRise++;
	task automatic chk(input string n, input lcr_word_t g, input lcr_word_t e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input lcr_addr_t a, input lcr_word_t d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		#1;
	endtask
	task automatic rd(input lcr_addr_t a, input lcr_word_t e);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1 chk("rdData", rdData, e);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		results();
	end
	initial begin
		reset = 1'b1;
		addr = 8'h00;
		wrData = 16'h0000;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		perLanePatternEnable = 1'b0;
		run = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(8'h3B, 16'h0000);
		rd(8'h3C, 16'h0000);
		rd(8'h43, 16'h0000);
		wr(8'h3C, 16'hA5C3);
		chk("digitalOff", 16'(dig), 16'h000A);
		chk("driverOff", 16'(drv), 16'h0005);
		chk("analogOff", 16'(ana), 16'h000C);
		chk("flipData", 16'(flip), 16'h0003);
		rd(8'h3C, 16'hA5C3);
		wr(8'h3B, 16'hFF74);
		chk("pat15", 16'(pat15), 16'h0000);
		@(posedge clk);
		perLanePatternEnable <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("pat15", 16'(pat15), 16'h0003);
		chk("pat16", 16'(pat16), 16'h0005);
		rd(8'h3B, 16'h0074);
		$display("register test done");
		foreach (dl[i]) begin
			wr(8'h43, 16'((dl[i] & 15) << 1));
			chk("delay", {12'h000, dly}, 16'(dl[i] & 15));
			chk("shiftPs", shiftPs, 16'(dl[i] * 110));
			rd(8'h43, 16'((dl[i] & 15) << 1));
		end
		wr(8'h44, 16'hFFFF);
		rd(8'h44, 16'h0000);
		rd(8'h3C, 16'hA5C3);
		$display("delay test done");
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		rd(8'h3C, 16'h0000);
		run <= 1'b1;
		repeat (30) @(posedge clk);
		run <= 1'b0;
		repeat (10) @(posedge clk);
		chk("rises", 16'(nRise), 16'h0004);
		$display("link test done");
		results();
	end
endmodule

// File: verilog/lcr_params.svh
// constants for the lane 13-16 output control register bank
// included by the package and the design module
`ifndef LCR_PARAMS_SVH
`define LCR_PARAMS_SVH
`define LCR_ADDR_PATTERN 8'h3B
`define LCR_ADDR_POWER 8'h3C
`define LCR_ADDR_CLKDLY 8'h43
`define LCR_RESET_VALUE 16'h0000
`define LCR_PAT15_HI 7
`define LCR_PAT15_LO 5
`define LCR_PAT16_HI 4
`define LCR_PAT16_LO 2
`define LCR_DIG_HI 15
`define LCR_DIG_LO 12
`define LCR_DRV_HI 11
`define LCR_DRV_LO 8
`define LCR_ANA_HI 7
`define LCR_ANA_LO 4
`define LCR_INV_HI 3
`define LCR_INV_LO 0
`define LCR_DLY_HI 4
`define LCR_DLY_LO 1
`define LCR_DLY_STEP_PS 110
`define LCR_CLK_PERIOD_NS 100
`define LCR_PATTERN_MASK 16'h00FC
`define LCR_CLKDLY_MASK 16'h001E
`define LCR_INV_LANE16 3
`define LCR_INV_LANE15 2
`define LCR_GAP_MAX 4'hF
`define LCR_RISE_GAP 4'h2
`endif

// File: verilog/lcr_pkg.sv
// types shared by the lane 13-16 output control register bank
// assumes lcr_params.svh is on the include path
`include "lcr_params.svh"
package lcr_pkg;
	typedef logic [15:0] lcr_word_t;
	typedef logic [7:0] lcr_addr_t;
	typedef logic [2:0] lcr_pattern_t;
	typedef logic [3:0] lcr_lane_t;
	typedef logic signed [3:0] lcr_delay_t;
	typedef enum logic [1:0] {LCR_IDLE, LCR_HIGH, LCR_LOW} lcr_clk_state_t;
endpackage

// File: verilog/lcr_regs.sv
// register bank for lanes/channels 13-16 plus forwarded clock edge tracker
// assumes a single 10 MHz clock, sync active-high reset, and a slow bit clock input
`timescale 1ns/1ps
`include "lcr_params.svh"
module lcr_regs
	import lcr_pkg::*;
#(
	parameter int STEP_PS = `LCR_DLY_STEP_PS
) (
	input wire logic clk, // system clock
	input wire logic reset, // sync reset, active high
	input wire lcr_addr_t addr, // register address
	input wire lcr_word_t wrData, // write data
	input wire logic wrStrobe, // write strobe
	input wire logic rdStrobe, // read strobe
	output lcr_word_t rdData, // read data, cycle after strobe
	input wire logic perLanePatternEnable, // independent-pattern select from another register
	input wire logic forwardedBitClock, // forwarded clock, asynchronous
	output lcr_pattern_t laneFifteenPatternCode, // active lane 15 pattern
	output lcr_pattern_t laneSixteenPatternCode, // active lane 16 pattern
	output lcr_lane_t digitalOff, // channels 16..13, bit3=16
	output lcr_lane_t driverOff, // lanes 16..13, bit3=16
	output lcr_lane_t analogOff, // channels 16..13, bit3=16
	output lcr_lane_t flipData, // lanes 16..13, bit3=16
	output lcr_delay_t forwardedClockDelay, // signed step count
	output logic signed [15:0] forwardedClockShiftPs, // shift in ps, positive = later
	output logic forwardedClockRise // one-cycle pulse per detected rising edge
);
	lcr_word_t patReg, patNext, pwrReg, pwrNext, dlyReg, dlyNext, rdReg, rdNext;
	logic [2:0] syncReg, syncNext;
	logic levelReg, levelNext;
	logic riseReg, riseNext;
	logic [3:0] gapReg, gapNext;
	logic wrPat, wrPwr, wrDly;

	function automatic lcr_word_t readMux(input lcr_addr_t a, input lcr_word_t p, input lcr_word_t w,
		input lcr_word_t d);
		case (a)
			`LCR_ADDR_PATTERN: readMux = p;
			`LCR_ADDR_POWER: readMux = w;
			`LCR_ADDR_CLKDLY: readMux = d;
			default: readMux = `LCR_RESET_VALUE;
		endcase
	endfunction

	function automatic logic hitReg(input lcr_addr_t a, input lcr_addr_t r);
		hitReg = (a == r);
	endfunction

	// unmapped addresses read zero and ignore writes
	function automatic logic isMapped(input lcr_addr_t a);
		isMapped = hitReg(a, `LCR_ADDR_PATTERN) || hitReg(a, `LCR_ADDR_POWER) || hitReg(a, `LCR_ADDR_CLKDLY);
	endfunction

	assign wrPat = wrStrobe && hitReg(addr, `LCR_ADDR_PATTERN);
	assign wrPwr = wrStrobe && hitReg(addr, `LCR_ADDR_POWER);
	assign wrDly = wrStrobe && hitReg(addr, `LCR_ADDR_CLKDLY);

	always_comb begin
		patNext = patReg;
		pwrNext = pwrReg;
		dlyNext = dlyReg;
		rdNext = `LCR_RESET_VALUE;
		// unused bits are held at zero even if the host breaks the write-zero convention
		if (wrPat)
			patNext = wrData & `LCR_PATTERN_MASK;
		if (wrPwr)
			pwrNext = wrData;
		if (wrDly)
			dlyNext = wrData & `LCR_CLKDLY_MASK;
		if (rdStrobe)
			rdNext = readMux(addr, patReg, pwrReg, dlyReg);
		if (reset) begin
			patNext = `LCR_RESET_VALUE;
			pwrNext = `LCR_RESET_VALUE;
			dlyNext = `LCR_RESET_VALUE;
			rdNext = `LCR_RESET_VALUE;
		end
	end

	always_ff @(posedge clk) begin
		patReg <= patNext;
		pwrReg <= pwrNext;
		dlyReg <= dlyNext;
		rdReg <= rdNext;
	end

	// bit clock edge finder: three stages, a new level counts once stages two and three agree
	always_comb begin
		syncNext = {syncReg[1:0], forwardedBitClock};
		levelNext = (syncReg[1] == syncReg[2]) ? syncReg[2] : levelReg;
		riseNext = levelNext & ~levelReg;
		if (reset) begin
			syncNext = 3'h0;
			levelNext = 1'h0;
			riseNext = 1'h0;
		end
	end

	always_ff @(posedge clk) begin
		syncReg <= syncNext;
		levelReg <= levelNext;
		riseReg <= riseNext;
	end

	// cycles since the last detected edge, saturating; feeds the pulse spacing check
	always_comb begin
		gapNext = gapReg;
		if (riseReg)
			gapNext = 4'h0;
		else if (gapReg != `LCR_GAP_MAX)
			gapNext = gapReg + 4'h1;
		if (reset)
			gapNext = `LCR_GAP_MAX;
	end

	always_ff @(posedge clk) begin
		gapReg <= gapNext;
	end

	assign rdData = rdReg;
	assign laneFifteenPatternCode = perLanePatternEnable ? patReg[`LCR_PAT15_HI:`LCR_PAT15_LO] : 3'h0;
	assign laneSixteenPatternCode = perLanePatternEnable ? patReg[`LCR_PAT16_HI:`LCR_PAT16_LO] : 3'h0;
	assign digitalOff = pwrReg[`LCR_DIG_HI:`LCR_DIG_LO];
	assign driverOff = pwrReg[`LCR_DRV_HI:`LCR_DRV_LO];
	assign analogOff = pwrReg[`LCR_ANA_HI:`LCR_ANA_LO];
	assign flipData = pwrReg[`LCR_INV_HI:`LCR_INV_LO];
	assign forwardedClockDelay = lcr_delay_t'(dlyReg[`LCR_DLY_HI:`LCR_DLY_LO]);
	assign forwardedClockShiftPs = 16'(forwardedClockDelay * STEP_PS);
	assign forwardedClockRise = riseReg;

	// pattern register
	a_pattern_write: assert property (@(posedge clk) disable iff (reset)
		wrPat |=> patReg == ($past(wrData) & `LCR_PATTERN_MASK))
		else $error("pattern register not updated");

	a_pattern_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrPat |=> $stable(patReg))
		else $error("pattern register changed without write");

	a_pattern_gate: assert property (@(posedge clk) disable iff (reset)
		!perLanePatternEnable |-> laneFifteenPatternCode == 3'h0 && laneSixteenPatternCode == 3'h0)
		else $error("pattern shown while per-lane disabled");

	a_lane15_pass: assert property (@(posedge clk) disable iff (reset)
		perLanePatternEnable |-> laneFifteenPatternCode == patReg[`LCR_PAT15_HI:`LCR_PAT15_LO])
		else $error("lane 15 pattern not passed through");

	a_lane16_pass: assert property (@(posedge clk) disable iff (reset)
		perLanePatternEnable |-> laneSixteenPatternCode == patReg[`LCR_PAT16_HI:`LCR_PAT16_LO])
		else $error("lane 16 pattern not passed through");

	a_pattern_unused: assert property (@(posedge clk) disable iff (reset)
		(patReg & ~`LCR_PATTERN_MASK) == `LCR_RESET_VALUE)
		else $error("unused pattern bits not zero");

	// power and invert register
	a_power_write: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> {digitalOff, driverOff, analogOff, flipData} == $past(wrData))
		else $error("power register not updated");

	a_digital_write: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> digitalOff == $past(wrData[`LCR_DIG_HI:`LCR_DIG_LO]))
		else $error("digital bits not written");

	a_digital_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrPwr |=> $stable(digitalOff))
		else $error("digital bits changed without write");

	a_driver_write: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> driverOff == $past(wrData[`LCR_DRV_HI:`LCR_DRV_LO]))
		else $error("driver bits not written");

	a_driver_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrPwr |=> $stable(driverOff))
		else $error("driver bits changed without write");

	a_analog_write: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> analogOff == $past(wrData[`LCR_ANA_HI:`LCR_ANA_LO]))
		else $error("analog bits not written");

	a_analog_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrPwr |=> $stable(analogOff))
		else $error("analog bits changed without write");

	a_invert_map: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> flipData[`LCR_INV_LANE16] == $past(wrData[`LCR_INV_LANE16]))
		else $error("lane 16 invert mis-mapped");

	a_invert_lane15: assert property (@(posedge clk) disable iff (reset)
		wrPwr |=> flipData[`LCR_INV_LANE15] == $past(wrData[`LCR_INV_LANE15]))
		else $error("lane 15 invert mis-mapped");

	a_invert_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrPwr |=> $stable(flipData))
		else $error("invert bits changed without write");

	// reset values
	a_reset_zero: assert property (@(posedge clk) $past(reset) |-> patReg == 16'h0 && pwrReg == 16'h0)
		else $error("registers not zero after reset");

	a_reset_read: assert property (@(posedge clk) $past(reset) |-> rdData == `LCR_RESET_VALUE)
		else $error("read data not zero after reset");

	a_reset_outputs: assert property (@(posedge clk)
		$past(reset) |-> laneFifteenPatternCode == 3'h0 && digitalOff == 4'h0 && flipData == 4'h0)
		else $error("control outputs not zero after reset");

	// clock delay register
	a_delay_write: assert property (@(posedge clk) disable iff (reset)
		wrDly |=> forwardedClockDelay == lcr_delay_t'($past(wrData[`LCR_DLY_HI:`LCR_DLY_LO])))
		else $error("delay field not written");

	a_delay_step: assert property (@(posedge clk) disable iff (reset)
		wrDly && wrData[`LCR_DLY_HI:`LCR_DLY_LO] == 4'h1 |=> forwardedClockShiftPs == 16'(STEP_PS))
		else $error("delay step wrong");

	a_delay_hold: assert property (@(posedge clk) disable iff (reset)
		!reset && !wrDly |=> $stable(forwardedClockDelay))
		else $error("delay changed without write");

	a_delay_unused: assert property (@(posedge clk) disable iff (reset)
		(dlyReg & ~`LCR_CLKDLY_MASK) == `LCR_RESET_VALUE)
		else $error("unused delay bits not zero");

	a_delay_zero: assert property (@(posedge clk) disable iff (reset)
		forwardedClockDelay == 4'sh0 |-> forwardedClockShiftPs == 16'sh0000)
		else $error("zero delay gives a shift");

	a_delay_sign: assert property (@(posedge clk) disable iff (reset)
		forwardedClockDelay < 4'sh0 |-> forwardedClockShiftPs < 16'sh0000)
		else $error("negative delay not negative shift");

	a_delay_minus_one: assert property (@(posedge clk) disable iff (reset)
		forwardedClockDelay == 4'shF |-> forwardedClockShiftPs == -16'(STEP_PS))
		else $error("all-ones delay not one step early");

	a_delay_two: assert property (@(posedge clk) disable iff (reset)
		forwardedClockDelay == 4'sh2 |-> forwardedClockShiftPs == 16'(STEP_PS + STEP_PS))
		else $error("two-step delay wrong");

	a_delay_positive: assert property (@(posedge clk) disable iff (reset)
		forwardedClockDelay > 4'sh0 |-> forwardedClockShiftPs > 16'sh0000)
		else $error("positive delay not a later edge");

	// read port
	a_read_data: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && addr == `LCR_ADDR_CLKDLY && !wrStrobe |=> rdData == dlyReg)
		else $error("read data mismatch");

	a_read_pattern: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && addr == `LCR_ADDR_PATTERN && !wrStrobe |=> rdData == patReg)
		else $error("pattern read mismatch");

	a_read_power: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && addr == `LCR_ADDR_POWER && !wrStrobe |=> rdData == pwrReg)
		else $error("power read mismatch");

	a_read_unmapped: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && !isMapped(addr) |=> rdData == `LCR_RESET_VALUE)
		else $error("unmapped read not zero");

	a_read_idle: assert property (@(posedge clk) disable iff (reset)
		!rdStrobe |=> rdData == `LCR_RESET_VALUE)
		else $error("read data outside its cycle");

	a_unmapped_write: assert property (@(posedge clk) disable iff (reset)
		!reset && wrStrobe && !isMapped(addr) |=> $stable(patReg) && $stable(pwrReg) && $stable(dlyReg))
		else $error("unmapped write changed a register");

	// forwarded clock edge finder
	a_rise_single: assert property (@(posedge clk) disable iff (reset)
		forwardedClockRise |=> !forwardedClockRise)
		else $error("edge pulse longer than one cycle");

	a_rise_level: assert property (@(posedge clk) disable iff (reset)
		forwardedClockRise |-> levelReg)
		else $error("edge pulse without settled high level");

	a_rise_spacing: assert property (@(posedge clk) disable iff (reset)
		forwardedClockRise |-> gapReg >= `LCR_RISE_GAP)
		else $error("edge pulses too close together");
endmodule
